/* src/csw_status_change.sv */
// How it works
// - Masked source reads as zero flag
// - Unmasked event sets flag, raises interrupt
// - Clear mode one: write one clears flag
// - Clear mode zero: a flag register read clears all flags
// - Flag bits 7-4 read zero, ignore writes
// - Bit 3 sets on either card-detect change
// - Bit 2: memory card READY rise; I/O zero
// - Bit 1: memory card battery warning; I/O zero
// - Bit 0: battery dead or card status change
// - Ring indicate mode: bit 0 shows pin
// - Config bits 7-4 pick interrupt route
// - Pinless route codes need serial scheme
// - Config bit 3 masks card-detect changes
// - Config bit 2 masks READY rise
// - Config bit 1 masks battery warning
// - Config bit 0 masks dead/status change
// - Disabled window never claims a cycle
// - Window enable bit map: I/O 7,6; memory 4-0
// - Window enable bit 5 reads zero
// - All three registers reset to zero
// - Registers at index, second socket, alias
// - Card type selects memory or I/O meaning
// - PCI routing with PCI interrupt enable sends interrupt to PCI line
// - General control bit 7 enables ring indicate
`default_nettype none
module csw_status_change import csw_pkg::*; (
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic ce,
  // Register port
  input wire logic [11:0] regAddr,
  input wire logic regRead,
  input wire logic regWrite,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  // Socket and control bits
  input wire logic socketSel,
  input wire logic flagClearWriteOne,
  input wire logic cardIsIo,
  input wire logic ringIndicateEn,
  input wire logic pciCscRouteEn,
  input wire logic pciIntEnable,
  input wire logic serialIrqMode,
  // Card pins
  input wire logic card_detect_a_n,
  input wire logic card_detect_b_n,
  input wire logic cardReady,
  input wire logic batteryDetect1,
  input wire logic batteryDetect2,
  input wire logic card_status_change_in,
  input wire logic ring_indicate_n,
  // Window hits from the address decoders
  input wire logic [WIN_MEM_N-1:0] memWinHit,
  input wire logic [WIN_IO_N-1:0] ioWinHit,
  output logic cycleClaim,
  output logic [WIN_MEM_N-1:0] memWinEnable,
  output logic [WIN_IO_N-1:0] ioWinEnable,
  // Interrupt outputs
  output logic [15:0] hostIrqLine,
  output logic system_mgmt_interrupt,
  output logic pciCscInt
);
  // Register decode for one index on this socket
  function automatic logic regHit(input logic [11:0] addr, input logic [7:0] idx, input logic sockB);
    logic [7:0] sockIdx;
    sockIdx = idx + (sockB ? SOCKET_B_STRIDE : 8'h00);
    regHit = (addr == {4'h0, sockIdx}) || (addr == (ALIAS_BASE | {4'h0, idx}));
  endfunction

  logic [7:0] flags_q, flags_d;
  logic [7:0] config_q, config_d;
  logic [7:0] winEn_q, winEn_d;
  logic [7:0] rdata_q, rdata_d;
  logic [15:0] irqLine_q, irqLine_d;
  logic smi_q, smi_d;
  logic pciInt_q, pciInt_d;

  logic hitFlags, hitConfig, hitWinEn;
  logic batDead, batWarn, ringActive;
  logic [SRC_N-1:0] srcLevel, srcRise, srcFall;
  logic [7:0] events, setBits, clrBits, mask, flagsView;
  logic anyIrq, toPci;
  logic [15:0] routedLines;
  logic routedSmi;

  // Battery state from the two detect pins
  assign batDead = ~batteryDetect1;
  assign batWarn = batteryDetect1 & ~batteryDetect2;
  assign ringActive = ringIndicateEn & ~ring_indicate_n;

  assign srcLevel[SRC_CD_A] = card_detect_a_n;
  assign srcLevel[SRC_CD_B] = card_detect_b_n;
  assign srcLevel[SRC_READY] = cardReady;
  assign srcLevel[SRC_DEAD] = batDead;
  assign srcLevel[SRC_WARN] = batWarn;
  assign srcLevel[SRC_CARD_STATUS_CHANGE_IN] = card_status_change_in;

  csw_edge_detect #(
    .N(SRC_N)
  ) u_edges (
    .core_clk(core_clk),
    .rstn(rstn),
    .ce(ce),
    .level(srcLevel),
    .rise(srcRise),
    .fall(srcFall)
  );

  assign hitFlags = regHit(regAddr, IDX_FLAGS, socketSel);
  assign hitConfig = regHit(regAddr, IDX_CONFIG, socketSel);
  assign hitWinEn = regHit(regAddr, IDX_WIN_EN, socketSel);

  // Source masks from the low configuration bits
  always_comb begin
    mask = 8'h00;
    mask[FLAG_CD_BIT] = config_q[FLAG_CD_BIT];
    mask[FLAG_READY_BIT] = config_q[FLAG_READY_BIT] & ~cardIsIo;
    mask[FLAG_WARN_BIT] = config_q[FLAG_WARN_BIT] & ~cardIsIo;
    mask[FLAG_DEAD_BIT] = config_q[FLAG_DEAD_BIT];
  end

  // Card events per flag bit
  always_comb begin
    events = 8'h00;
    events[FLAG_CD_BIT] = srcRise[SRC_CD_A] | srcFall[SRC_CD_A]
      | srcRise[SRC_CD_B] | srcFall[SRC_CD_B];
    events[FLAG_READY_BIT] = srcRise[SRC_READY];
    events[FLAG_WARN_BIT] = srcRise[SRC_WARN];
    events[FLAG_DEAD_BIT] = cardIsIo ? srcRise[SRC_CARD_STATUS_CHANGE_IN] : srcRise[SRC_DEAD];
  end

  // Flags as software sees them
  always_comb begin
    flagsView = flags_q & mask & FLAGS_IMPL_MASK;
    if (ringIndicateEn) begin
      flagsView[FLAG_DEAD_BIT] = ringActive & mask[FLAG_DEAD_BIT];
    end
  end

  // Flag register: a set in the clearing cycle wins
  always_comb begin
    setBits = events & mask;
    clrBits = 8'h00;
    if (hitFlags && regWrite && flagClearWriteOne) begin
      clrBits = regWdata;
    end else if (hitFlags && regRead && !flagClearWriteOne) begin
      clrBits = 8'hff;
    end
    flags_d = ((flags_q & ~clrBits) | setBits) & mask & FLAGS_IMPL_MASK;
  end

  // Writable registers
  always_comb begin
    config_d = config_q;
    winEn_d = winEn_q;
    if (regWrite && hitConfig) begin
      config_d = regWdata;
    end
    if (regWrite && hitWinEn) begin
      winEn_d = regWdata & WIN_EN_IMPL_MASK;
    end
  end

  // Read data, captured before a read-clear takes effect
  always_comb begin
    rdata_d = rdata_q;
    if (regRead) begin
      if (hitFlags) begin
        rdata_d = flagsView;
      end else if (hitConfig) begin
        rdata_d = config_q;
      end else if (hitWinEn) begin
        rdata_d = winEn_q & WIN_EN_IMPL_MASK;
      end else begin
        rdata_d = 8'h00;
      end
    end
  end

  // Interrupt request and its route
  always_comb begin
    anyIrq = |flagsView;
    toPci = pciCscRouteEn & pciIntEnable;
    pciInt_d = anyIrq & toPci;
  end

  csw_irq_route u_route (
    .routeCode(config_q[ROUTE_LSB +: ROUTE_W]),
    .serialIrqMode(serialIrqMode),
    .request(anyIrq & ~toPci),
    .hostIrqLine(routedLines),
    .systemMgmtInterrupt(routedSmi)
  );

  always_comb begin
    irqLine_d = routedLines;
    smi_d = routedSmi;
  end

  // Flag group
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      flags_q <= FLAGS_RESET;
    end else if (ce) begin
      flags_q <= flags_d;
    end
  end

  // Writable register group
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      config_q <= CONFIG_RESET;
      winEn_q <= WIN_EN_RESET;
    end else if (ce) begin
      config_q <= config_d;
      winEn_q <= winEn_d;
    end
  end

  // Read data group
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= RDATA_RESET;
    end else if (ce) begin
      rdata_q <= rdata_d;
    end
  end

  // Interrupt output group
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      irqLine_q <= 16'h0000;
      smi_q <= 1'b0;
      pciInt_q <= 1'b0;
    end else if (ce) begin
      irqLine_q <= irqLine_d;
      smi_q <= smi_d;
      pciInt_q <= pciInt_d;
    end
  end

  assign regRdata = rdata_q;
  assign hostIrqLine = irqLine_q;
  assign system_mgmt_interrupt = smi_q;
  assign pciCscInt = pciInt_q;

  // Window enables and cycle claim
  assign memWinEnable = winEn_q[WIN_MEM_LSB +: WIN_MEM_N];
  assign ioWinEnable = winEn_q[WIN_IO_LSB +: WIN_IO_N];
  assign cycleClaim = |(memWinHit & memWinEnable) | |(ioWinHit & ioWinEnable);
endmodule
`default_nettype wire

/* src/csw_pkg.sv */
`default_nettype none
package csw_pkg;
  // Register indexes for the first socket
  localparam logic [7:0] IDX_FLAGS = 8'h04;
  localparam logic [7:0] IDX_CONFIG = 8'h05;
  localparam logic [7:0] IDX_WIN_EN = 8'h06;
  // Second socket copy sits this far above the first
  localparam logic [7:0] SOCKET_B_STRIDE = 8'h40;
  // Socket base alias for the same registers
  localparam logic [11:0] ALIAS_BASE = 12'h800;

  // Reset values
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [7:0] WIN_EN_RESET = 8'h00;
  localparam logic [7:0] RDATA_RESET = 8'h00;

  // Writable and readable bits
  localparam logic [7:0] FLAGS_IMPL_MASK = 8'h0f;
  localparam logic [7:0] WIN_EN_IMPL_MASK = 8'hdf;

  // Flag and mask bit positions
  localparam int FLAG_CD_BIT = 3;
  localparam int FLAG_READY_BIT = 2;
  localparam int FLAG_WARN_BIT = 1;
  localparam int FLAG_DEAD_BIT = 0;

  // Routing field of the configuration register
  localparam int ROUTE_LSB = 4;
  localparam int ROUTE_W = 4;
  localparam logic [3:0] ROUTE_NONE = 4'h0;
  localparam logic [3:0] ROUTE_SMI = 4'h2;

  // Window enable field positions
  localparam int WIN_MEM_LSB = 0;
  localparam int WIN_MEM_N = 5;
  localparam int WIN_IO_LSB = 6;
  localparam int WIN_IO_N = 2;

  // Watched card inputs, order within the edge detector
  localparam int SRC_CD_A = 0;
  localparam int SRC_CD_B = 1;
  localparam int SRC_READY = 2;
  localparam int SRC_DEAD = 3;
  localparam int SRC_WARN = 4;
  localparam int SRC_CARD_STATUS_CHANGE_IN = 5;
  localparam int SRC_N = 6;
endpackage
`default_nettype wire

/* src/csw_edge_detect.sv */
`default_nettype none
module csw_edge_detect import csw_pkg::*; #(
  parameter int N = 6
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic ce,
  // Levels in, edges out
  input wire logic [N-1:0] level,
  output logic [N-1:0] rise,
  output logic [N-1:0] fall
);
  logic [N-1:0] prev_q, prev_d;
  logic armed_q, armed_d;

  always_comb begin
    prev_d = level;
    armed_d = 1'b1;
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      prev_q <= '0;
      armed_q <= 1'b0;
    end else if (ce) begin
      prev_q <= prev_d;
      armed_q <= armed_d;
    end
  end

  // No edges until the first sample after reset is held
  for (genvar i = 0; i < N; i++) begin : g_edge
    assign rise[i] = armed_q & ce & level[i] & ~prev_q[i];
    assign fall[i] = armed_q & ce & ~level[i] & prev_q[i];
  end
endmodule
`default_nettype wire

/* src/csw_irq_route.sv */
`default_nettype none
module csw_irq_route import csw_pkg::*; (
  // Route selection
  input wire logic [ROUTE_W-1:0] routeCode,
  input wire logic serialIrqMode,
  input wire logic request,
  // Routed request
  output logic [15:0] hostIrqLine,
  output logic systemMgmtInterrupt
);
  // Codes with no dedicated pin
  function automatic logic needsSerial(input logic [ROUTE_W-1:0] code);
    case (code)
      4'h1, 4'h2, 4'h6, 4'h8, 4'hd: needsSerial = 1'b1;
      default: needsSerial = 1'b0;
    endcase
  endfunction

  logic allowed;

  always_comb begin
    hostIrqLine = 16'h0000;
    systemMgmtInterrupt = 1'b0;
    allowed = request & (serialIrqMode | ~needsSerial(routeCode));
    if (allowed) begin
      if (routeCode == ROUTE_SMI) begin
        systemMgmtInterrupt = 1'b1;
      end else if (routeCode != ROUTE_NONE) begin
        hostIrqLine[routeCode] = 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* sim/csw_card_model.sv */
`default_nettype none
module csw_card_model (
  // Clock and command from the bench
  input wire logic core_clk,
  input wire logic [2:0] evSel,
  input wire logic evGo,
  // Card pins
  output logic card_detect_a_n,
  output logic card_detect_b_n,
  output logic cardReady,
  output logic batteryDetect1,
  output logic batteryDetect2,
  output logic card_status_change_in,
  output logic ring_indicate_n
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    {card_detect_a_n, card_detect_b_n, cardReady, card_status_change_in} = 4'hc;
    {batteryDetect1, batteryDetect2, ring_indicate_n} = 3'h7;
  end
  // Pins move on the rising edge, after the block has sampled them
  always @(posedge core_clk) begin
    if (evGo) begin
      case (evSel)
        3'h0: card_detect_a_n <= !card_detect_a_n;
        3'h1: card_detect_b_n <= !card_detect_b_n;
        3'h2: cardReady <= !cardReady;
        3'h3: batteryDetect2 <= 1'b0;
        3'h4: batteryDetect1 <= 1'b0;
        3'h6: card_status_change_in <= !card_status_change_in;
        default: ring_indicate_n <= !ring_indicate_n;
      endcase
    end
  end
endmodule
`default_nettype wire

/* sim/csw_status_change_monitor.sv */
`default_nettype none
module csw_status_change_monitor import csw_pkg::*; (
  // Clock and register port
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [11:0] regAddr,
  input wire logic regRead,
  input wire logic regWrite,
  input wire logic [7:0] regRdata,
  input wire logic cardIsIo,
  input wire logic serialIrqMode,
  // Windows and interrupts
  input wire logic [WIN_MEM_N-1:0] memWinHit,
  input wire logic [WIN_IO_N-1:0] ioWinHit,
  input wire logic [WIN_MEM_N-1:0] memWinEnable,
  input wire logic [WIN_IO_N-1:0] ioWinEnable,
  input wire logic cycleClaim,
  input wire logic [15:0] hostIrqLine,
  input wire logic system_mgmt_interrupt,
  input wire logic pciCscInt
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  sequence rdAt(idx);
    ce && regRead && regAddr[5:0] == idx;
  endsequence
  sequence quiet;
    !regRead && !regWrite && !$past(regRead) && !$past(regWrite);
  endsequence
  a_claim_gate: assert property (cycleClaim == |({ioWinHit, memWinHit} & {ioWinEnable, memWinEnable}))
    else $error("claim on disabled window");
  a_flag_high_zero: assert property (rdAt(6'h04) |=> regRdata[7:4] == 4'h0)
    else $error("flag bits 7-4 not zero");
  a_win_bit5: assert property (rdAt(6'h06) |=> !regRdata[5])
    else $error("window bit 5 not zero");
  a_io_flags_zero: assert property (cardIsIo ##0 rdAt(6'h04) |=> regRdata[2:1] == 2'h0)
    else $error("io card flag bits set");
  a_one_route: assert property ($onehot0({hostIrqLine, system_mgmt_interrupt, pciCscInt}) && !hostIrqLine[0])
    else $error("interrupt on several outputs");
  a_pinless_serial: assert property (!serialIrqMode && !$past(serialIrqMode) |->
    (hostIrqLine & 16'h2146) == 16'h0 && !system_mgmt_interrupt) else $error("pinless route used");
  a_irq_holds: assert property (|hostIrqLine ##0 quiet |=> |{hostIrqLine, system_mgmt_interrupt, pciCscInt})
    else $error("interrupt dropped with flag set");
  a_unmapped_zero: assert property (ce && regRead && regAddr == 12'h0ff |=> regRdata == 8'h00)
    else $error("unmapped read not zero");
endmodule
bind csw_status_change csw_status_change_monitor u_mon (.core_clk, .rstn, .ce, .regAddr, .regRead, .regWrite,
  .regRdata, .cardIsIo, .serialIrqMode, .memWinHit, .ioWinHit, .memWinEnable, .ioWinEnable, .cycleClaim,
  .hostIrqLine, .system_mgmt_interrupt, .pciCscInt);
`default_nettype wire

/* sim/tb.sv */
`default_nettype none
module tb import csw_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 1'b0, rstn = 1'b0, ce = 1'b1, regRead = 1'b0, regWrite = 1'b0, socketSel = 1'b0;
  logic flagClearWriteOne = 1'b0, cardIsIo = 1'b0, ringIndicateEn = 1'b0, pciCscRouteEn = 1'b0;
  logic pciIntEnable = 1'b0, serialIrqMode = 1'b0, evGo = 1'b0, rdSeen = 1'b0;
  logic [11:0] regAddr = 12'h000;
  logic [7:0] regWdata = 8'h00, regRdata;
  logic [WIN_MEM_N-1:0] memWinHit = 5'h00, memWinEnable;
  logic [WIN_IO_N-1:0] ioWinHit = 2'h0, ioWinEnable;
  logic [2:0] evSel = 3'h0;
  logic [15:0] hostIrqLine;
  logic card_detect_a_n, card_detect_b_n, cardReady, batteryDetect1, batteryDetect2, card_status_change_in;
  logic ring_indicate_n, cycleClaim, system_mgmt_interrupt, pciCscInt;
  logic [7:0] expQ[$];
  int err_count = 0, checks = 0;
  csw_status_change u_dut (.core_clk, .rstn, .ce, .regAddr, .regRead, .regWrite, .regWdata, .regRdata, .socketSel,
    .flagClearWriteOne, .cardIsIo, .ringIndicateEn, .pciCscRouteEn, .pciIntEnable, .serialIrqMode, .card_detect_a_n,
    .card_detect_b_n, .cardReady, .batteryDetect1, .batteryDetect2, .card_status_change_in, .ring_indicate_n,
    .memWinHit, .ioWinHit, .cycleClaim, .memWinEnable, .ioWinEnable, .hostIrqLine, .system_mgmt_interrupt, .pciCscInt);
  csw_card_model u_card (.core_clk, .evSel, .evGo, .card_detect_a_n, .card_detect_b_n, .cardReady, .batteryDetect1,
    .batteryDetect2, .card_status_change_in, .ring_indicate_n);
  always #12.5 core_clk = !core_clk;
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One compare per kind of result: read data, interrupt outputs, window outputs
  task automatic chk_rdata(input logic [7:0] got, input logic [7:0] exp);
    cmp({8'h00, got}, {8'h00, exp});
  endtask
  task automatic chk_irq(input logic [15:0] got, input logic [15:0] exp);
    cmp(got, exp);
  endtask
  task automatic chk_win(input logic [15:0] got, input logic [15:0] exp);
    cmp(got, exp);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    regAddr = a;
    regWdata = d;
    regWrite = 1'b1;
    @(negedge core_clk);
    regWrite = 1'b0;
    @(negedge core_clk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    expQ.push_back(e);
    regAddr = a;
    regRead = 1'b1;
    @(negedge core_clk);
    regRead = 1'b0;
    @(negedge core_clk);
  endtask
  task automatic ev(input logic [2:0] s);
    evSel = s;
    evGo = 1'b1;
    @(negedge core_clk);
    evGo = 1'b0;
    repeat (3) @(negedge core_clk);
  endtask
  task automatic note(input string s);
    $display("%s test done", s);
  endtask
  // Read results are compared against the oldest expectation
  always @(posedge core_clk) rdSeen <= regRead && ce && rstn;
  always @(negedge core_clk) begin
    if (rdSeen) chk_rdata(regRdata, expQ.pop_front());
    memWinHit <= 5'($urandom);
    ioWinHit <= 2'($urandom);
  end
  // Whole sequence needs about 5 us
  initial begin
    #100us;
    err_count++;
    close_out();
  end
  initial begin
    logic [7:0] v;
    logic [15:0] e;
    void'($urandom(32'h13e8));
    repeat (3) @(negedge core_clk);
    rstn = 1'b1;
    @(negedge core_clk);
    for (int i = 4; i < 7; i++) rd(12'(i), 8'h00);
    rd(12'h0ff, 8'h00);
    note("reset");
    v = 8'($urandom);
    wr(12'h005, v);
    rd(12'h805, v);
    socketSel = 1'b1;
    rd(12'h045, v);
    rd(12'h005, 8'h00);
    socketSel = 1'b0;
    // A write while the clock enable is low must not land
    ce = 1'b0;
    wr(12'h005, ~v);
    ce = 1'b1;
    rd(12'h005, v);
    note("config");
    for (int i = 0; i < 4; i++) begin
      v = 8'($urandom);
      wr(12'h006, v);
      rd(12'h006, v & 8'hdf);
      chk_win({9'h0, ioWinEnable, memWinEnable}, {9'h0, v[7:6], v[4:0]});
      chk_win({15'h0, cycleClaim}, {15'h0, |(memWinHit & v[4:0]) | |(ioWinHit & v[7:6])});
    end
    note("window");
    wr(12'h005, 8'h3f);
    ev(3'h0);
    ev(3'h2);
    ev(3'h3);
    ev(3'h4);
    chk_irq(hostIrqLine, 16'h0008);
    rd(12'h004, 8'h0f);
    rd(12'h004, 8'h00);
    chk_irq(hostIrqLine, 16'h0000);
    wr(12'h005, 8'h30);
    ev(3'h1);
    rd(12'h004, 8'h00);
    wr(12'h005, 8'h38);
    rd(12'h004, 8'h00);
    note("memory");
    flagClearWriteOne = 1'b1;
    ev(3'h0);
    rd(12'h004, 8'h08);
    wr(12'h004, 8'hf7);
    rd(12'h004, 8'h08);
    for (int s = 0; s < 2; s++) begin
      wr(12'h005, 8'h08);
      serialIrqMode = s[0];
      for (int c = 0; c < 16; c++) begin
        wr(12'h005, {c[3:0], 4'h8});
        e = (c == 0 || c == 2 || (!s[0] && c inside {1, 6, 8, 13})) ? 16'h0 : 16'h1 << c;
        chk_irq(hostIrqLine, e);
        chk_irq({15'h0, system_mgmt_interrupt}, {15'h0, s[0] && c == 2});
      end
    end
    pciCscRouteEn = 1'b1;
    pciIntEnable = 1'b1;
    repeat (2) @(negedge core_clk);
    chk_irq({hostIrqLine[15:1], pciCscInt}, 16'h0001);
    pciCscRouteEn = 1'b0;
    repeat (2) @(negedge core_clk);
    wr(12'h004, 8'h08);
    chk_irq(hostIrqLine, 16'h0000);
    rd(12'h004, 8'h00);
    note("route");
    flagClearWriteOne = 1'b0;
    cardIsIo = 1'b1;
    wr(12'h005, 8'h07);
    ev(3'h2);
    ev(3'h2);
    ev(3'h6);
    rd(12'h004, 8'h01);
    // Ring pin active while ring indicate is still off
    ev(3'h7);
    rd(12'h004, 8'h00);
    ringIndicateEn = 1'b1;
    rd(12'h004, 8'h01);
    ev(3'h7);
    rd(12'h004, 8'h00);
    note("io");
    // Mid-run reset with windows open and an interrupt standing
    wr(12'h006, 8'hff);
    wr(12'h005, 8'h31);
    ev(3'h7);
    chk_irq(hostIrqLine, 16'h0008);
    rstn = 1'b0;
    @(negedge core_clk);
    rstn = 1'b1;
    chk_irq(hostIrqLine, 16'h0000);
    chk_win({9'h0, ioWinEnable, memWinEnable}, 16'h0000);
    for (int i = 4; i < 7; i++) rd(12'(i), 8'h00);
    note("second reset");
    close_out();
  end
endmodule
`default_nettype wire
